/* File: src/tlc_pkg.sv */
// Constants, types and register map of the 10 Mb/s link control block
// Behaviour
// - Nibble interface mode drives a 2.5 MHz interface clock.
// - Serial interface mode drives a 10 MHz interface clock.
// - Clock recovery acquires at preamble, tracks while receiving, times receive.
// - Without transmit requests, send one normal_link_pulse every 16 ms.
// - Link pulses continue during reception and never cause collision.
// - Link-up flag is latching_low, readable at two status positions.
// - Link down goes up after more than seven pulses or qualified data.
// - Squelch inhibit zero needs data plus end_of_packet_marker; one needs data only.
// - Link up stays up on pulses or qualified valid data.
// - Link up drops after 81 to 83 ms without data or pulses.
// - Valid data needs recovery lock held three consecutive bit times.
// - Data seen while down defers link-up until the packet ends.
// - Going up never sets the latched link flag by itself.
// - Append an end_of_packet_marker after every transmitted packet.
// - Half duplex: carrier sense on transmit or receive.
// - Full duplex or repeater: carrier sense only on receive.
// - Half duplex: collision when receive overlaps transmit; full duplex never.
// - Jabber: collision except in full duplex, transmit blocked, pulses sent, latching_high flag set.
// - Jabber inhibit zero enables detection, one disables; resets to zero.
// - Heartbeat pulse on collision after transmit enable falls, when enabled.
// - Heartbeat only in node, half duplex, link up, inhibit zero.
// - One bit time counts as 100 ns.
package tlc_pkg;

	localparam int CLK_MHZ         = 200;
	localparam int CLK_NS          = 5;
	localparam int BIT_NS          = 100;
	localparam int BIT_CYC         = (BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int MII_PERIOD_NS   = 400;
	localparam int SER_PERIOD_NS   = 100;
	localparam int MII_HALF_CYC    = MII_PERIOD_NS / 2 / CLK_NS;
	localparam int SER_HALF_CYC    = SER_PERIOD_NS / 2 / CLK_NS;
	localparam int LP_PERIOD_MS    = 16;
	localparam int LP_PERIOD_CYC   = LP_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int LP_WIDTH_NS     = 100;
	localparam int LP_WIDTH_CYC    = (LP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
	localparam int LINK_TMO_MS     = 82;
	localparam int LINK_TMO_CYC    = LINK_TMO_MS * 1000 * CLK_MHZ;
	localparam int LP_UP_COUNT     = 8;
	localparam int VALID_BITS      = 3;
	localparam int VALID_CYC       = VALID_BITS * BIT_CYC;
	localparam int JAB_MAX_MS      = 20;
	localparam int JAB_MAX_CYC     = JAB_MAX_MS * 1000 * CLK_MHZ;
	localparam int JAB_OFF_MS      = 500;
	localparam int JAB_OFF_CYC     = JAB_OFF_MS * 1000 * CLK_MHZ;
	localparam int SQE_BITS        = 10;
	localparam int SQE_CYC         = SQE_BITS * BIT_CYC;

	localparam logic [4:0] REG_STATUS = 5'h01;
	localparam logic [4:0] REG_MODE   = 5'h10;
	localparam logic [4:0] REG_DETAIL = 5'h11;
	localparam logic [4:0] REG_OPS    = 5'h12;

	localparam int ST_LINK_BIT    = 2;
	localparam int DT_LINK_BIT    = 0;
	localparam int DT_JAB_BIT     = 2;
	localparam int OP_SQL_INH_BIT = 0;
	localparam int OP_SQE_INH_BIT = 2;
	localparam int OP_JAB_INH_BIT = 5;
	localparam int MD_SERIAL_BIT  = 0;
	localparam int MD_FULL_BIT    = 1;
	localparam int MD_RPT_BIT     = 2;

	typedef enum logic [1:0] {
		LINK_DOWN = 2'b00,
		LINK_WAIT = 2'b01,
		LINK_UP   = 2'b11
	} tlc_link_t;

	typedef enum logic [0:0] {
		JAB_WATCH = 1'b0,
		JAB_LOCK  = 1'b1
	} tlc_jab_t;

	typedef struct packed {
		tlc_link_t   link;
		logic [3:0]  lp_cnt;
		logic        marker_seen;
		logic        data_seen;
		logic [31:0] link_tmr;
		logic [15:0] lock_cnt;
		logic        data_valid;
		logic [31:0] lp_tmr;
		logic        lp_out;
		logic [15:0] div_cnt;
		logic        mac_clk;
		logic        tx_en_d;
		tlc_jab_t    jab;
		logic [31:0] jab_tmr;
		logic [15:0] sqe_cnt;
		logic        sqe;
		logic        crs;
		logic        col;
		logic        line_tx;
		logic        marker_out;
		logic        pll_acq;
		logic        link_ll;
		logic        jab_lh;
		logic        sql_inh;
		logic        sqe_inh;
		logic        jab_inh;
		logic        serial;
		logic        full_dup;
		logic        repeater;
		logic [15:0] rdata;
	} tlc_state_t;

	localparam tlc_state_t TLC_STATE_RST = '0;

endpackage

/* File: src/tlc_link_ctrl.sv */
// Control logic of a 10 Mb/s twisted-pair link: clocks, link monitor, carrier, jabber, heartbeat
//
// Design decisions made here: strobed register access and the address map.
module tlc_link_ctrl
	import tlc_pkg::*;
#(
	parameter int LP_PERIOD = LP_PERIOD_CYC,
	parameter int LINK_TMO  = LINK_TMO_CYC,
	parameter int JAB_MAX   = JAB_MAX_CYC,
	parameter int JAB_OFF   = JAB_OFF_CYC,
	parameter int SQE_LEN   = SQE_CYC,
	parameter int VALID_LEN = VALID_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        mac_tx_en,
	output logic             mac_clk,
	output logic             mac_crs,
	output logic             mac_col,
	input  wire logic        rx_activity,
	input  wire logic        rx_pll_lock,
	input  wire logic        rx_link_pulse,
	input  wire logic        rx_idle_marker,
	output logic             pll_acquire,
	output logic             line_tx_en,
	output logic             line_link_pulse,
	output logic             line_idle_marker
);

	tlc_state_t s_q;
	tlc_state_t s_d;

	logic link_live;
	logic rd_link;
	logic rd_detail;
	logic tx_fall;
	logic sqe_en;
	logic refresh;
	logic jab_set;
	logic tx_active;

	always_comb begin
		s_d = s_q;
		link_live = (s_q.link == LINK_UP);
		rd_link = reg_rd && (reg_addr == REG_STATUS || reg_addr == REG_DETAIL);
		rd_detail = reg_rd && (reg_addr == REG_DETAIL);
		tx_fall = s_q.tx_en_d && !mac_tx_en;
		refresh = 1'b0;
		jab_set = 1'b0;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				REG_OPS: begin
					s_d.sql_inh = reg_wdata[OP_SQL_INH_BIT];
					s_d.sqe_inh = reg_wdata[OP_SQE_INH_BIT];
					s_d.jab_inh = reg_wdata[OP_JAB_INH_BIT];
				end
				REG_MODE: begin
					s_d.serial = reg_wdata[MD_SERIAL_BIT];
					s_d.full_dup = reg_wdata[MD_FULL_BIT];
					s_d.repeater = reg_wdata[MD_RPT_BIT];
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		s_d.rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				REG_STATUS: begin
					s_d.rdata[ST_LINK_BIT] = s_q.link_ll;
				end
				REG_DETAIL: begin
					s_d.rdata[DT_LINK_BIT] = s_q.link_ll;
					s_d.rdata[DT_JAB_BIT] = s_q.jab_lh;
				end
				REG_OPS: begin
					s_d.rdata[OP_SQL_INH_BIT] = s_q.sql_inh;
					s_d.rdata[OP_SQE_INH_BIT] = s_q.sqe_inh;
					s_d.rdata[OP_JAB_INH_BIT] = s_q.jab_inh;
				end
				REG_MODE: begin
					s_d.rdata[MD_SERIAL_BIT] = s_q.serial;
					s_d.rdata[MD_FULL_BIT] = s_q.full_dup;
					s_d.rdata[MD_RPT_BIT] = s_q.repeater;
				end
				default: begin
				end
			endcase
		end

		// Interface clock divider; a mode change applies at once to the half period in progress
		if (s_q.div_cnt >= 16'((s_q.serial ? SER_HALF_CYC : MII_HALF_CYC) - 1)) begin
			s_d.div_cnt = 16'h0000;
			s_d.mac_clk = !s_q.mac_clk;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 16'h0001;
		end

		// Recovery loop runs from the first preamble edge for as long as carrier lasts
		s_d.pll_acq = rx_activity;

		// Lock must hold for three bit times before activity counts as data
		if (rx_activity && rx_pll_lock) begin
			if (s_q.lock_cnt >= 16'(VALID_LEN - 1)) begin
				s_d.data_valid = 1'b1;
			end else begin
				s_d.lock_cnt = s_q.lock_cnt + 16'h0001;
			end
		end else begin
			s_d.lock_cnt = 16'h0000;
			s_d.data_valid = 1'b0;
		end

		// Link monitor
		s_d.link_tmr = s_q.link_tmr + 32'h0000_0001;
		case (s_q.link)
			LINK_DOWN: begin
				s_d.marker_seen = 1'b0;
				s_d.data_seen = 1'b0;
				if (rx_link_pulse) begin
					s_d.link_tmr = 32'h0000_0000;
					s_d.lp_cnt = s_q.lp_cnt + 4'h1;
					if (s_q.lp_cnt >= 4'(LP_UP_COUNT - 1)) begin
						s_d.link = LINK_UP;
						s_d.lp_cnt = 4'h0;
					end
				end else if (s_q.link_tmr >= 32'(LINK_TMO - 1)) begin
					// Stale pulses from a long gap do not add up to a link
					s_d.lp_cnt = 4'h0;
					s_d.link_tmr = 32'h0000_0000;
				end
				if (s_q.data_valid) begin
					s_d.link = LINK_WAIT;
					s_d.lp_cnt = 4'h0;
				end
			end
			LINK_WAIT: begin
				if (rx_idle_marker) begin
					s_d.marker_seen = 1'b1;
				end
				if (!rx_activity) begin
					s_d.link_tmr = 32'h0000_0000;
					if (s_q.sql_inh || s_q.marker_seen || rx_idle_marker) begin
						s_d.link = LINK_UP;
					end else begin
						s_d.link = LINK_DOWN;
					end
				end
			end
			LINK_UP: begin
				if (s_q.data_valid) begin
					s_d.data_seen = 1'b1;
				end
				if (rx_link_pulse) begin
					refresh = 1'b1;
				end
				if (s_q.sql_inh && s_q.data_valid) begin
					refresh = 1'b1;
				end
				if (!s_q.sql_inh && s_q.data_seen && rx_idle_marker) begin
					refresh = 1'b1;
					s_d.data_seen = 1'b0;
				end
				if (refresh) begin
					s_d.link_tmr = 32'h0000_0000;
				end else if (s_q.link_tmr >= 32'(LINK_TMO - 1)) begin
					s_d.link = LINK_DOWN;
					s_d.link_tmr = 32'h0000_0000;
				end
			end
			default: begin
				s_d.link = LINK_DOWN;
			end
		endcase

		// Latched link flag: a read reloads the live value, a failure clears it
		if (rd_link) begin
			s_d.link_ll = link_live;
		end
		if (s_d.link != LINK_UP) begin
			s_d.link_ll = 1'b0;
		end

		// Jabber watchdog
		s_d.tx_en_d = mac_tx_en;
		case (s_q.jab)
			JAB_WATCH: begin
				if (mac_tx_en) begin
					s_d.jab_tmr = s_q.jab_tmr + 32'h0000_0001;
				end else begin
					s_d.jab_tmr = 32'h0000_0000;
				end
				if (mac_tx_en && !s_q.jab_inh && s_q.jab_tmr >= 32'(JAB_MAX - 1)) begin
					s_d.jab = JAB_LOCK;
					s_d.jab_tmr = 32'h0000_0000;
					jab_set = 1'b1;
				end
			end
			JAB_LOCK: begin
				// Release only once the MAC has let go, so no packet tail leaks out
				if (s_q.jab_tmr >= 32'(JAB_OFF - 1)) begin
					if (!mac_tx_en) begin
						s_d.jab = JAB_WATCH;
						s_d.jab_tmr = 32'h0000_0000;
					end
				end else begin
					s_d.jab_tmr = s_q.jab_tmr + 32'h0000_0001;
				end
			end
			default: begin
				s_d.jab = JAB_WATCH;
			end
		endcase

		// Latched jabber flag: the set wins over a read in the same cycle
		if (rd_detail) begin
			s_d.jab_lh = (s_q.jab == JAB_LOCK);
		end
		if (jab_set) begin
			s_d.jab_lh = 1'b1;
		end

		s_d.line_tx = mac_tx_en && (s_d.jab == JAB_WATCH);
		s_d.marker_out = tx_fall && (s_q.jab == JAB_WATCH);

		// Idle pulses run whenever nothing real goes out, reception or not
		tx_active = mac_tx_en && (s_q.jab == JAB_WATCH);
		if (tx_active) begin
			s_d.lp_tmr = 32'h0000_0000;
		end else if (s_q.lp_tmr >= 32'(LP_PERIOD - 1)) begin
			s_d.lp_tmr = 32'h0000_0000;
		end else begin
			s_d.lp_tmr = s_q.lp_tmr + 32'h0000_0001;
		end
		s_d.lp_out = !tx_active && (s_d.lp_tmr >= 32'(LP_PERIOD - LP_WIDTH_CYC));

		// Heartbeat after each packet while sqe_en holds: node, half duplex, link up, inhibit clear
		sqe_en = !s_q.repeater && !s_q.full_dup && link_live && !s_q.sqe_inh;
		if (!sqe_en) begin
			s_d.sqe = 1'b0;
			s_d.sqe_cnt = 16'h0000;
		end else if (tx_fall) begin
			s_d.sqe = 1'b1;
			s_d.sqe_cnt = 16'h0000;
		end else if (s_q.sqe) begin
			if (s_q.sqe_cnt >= 16'(SQE_LEN - 1)) begin
				s_d.sqe = 1'b0;
			end else begin
				s_d.sqe_cnt = s_q.sqe_cnt + 16'h0001;
			end
		end

		// Carrier and collision toward the MAC; link pulses never enter rx_activity
		if (s_q.full_dup || s_q.repeater) begin
			s_d.crs = rx_activity;
		end else begin
			s_d.crs = rx_activity || mac_tx_en;
		end
		if (s_q.full_dup) begin
			s_d.col = 1'b0;
		end else begin
			s_d.col = (mac_tx_en && rx_activity) || (s_d.jab == JAB_LOCK) || s_d.sqe;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s_q <= TLC_STATE_RST;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign mac_clk = s_q.mac_clk;
	assign mac_crs = s_q.crs;
	assign mac_col = s_q.col;
	assign pll_acquire = s_q.pll_acq;
	assign line_tx_en = s_q.line_tx;
	assign line_link_pulse = s_q.lp_out;
	assign line_idle_marker = s_q.marker_out;

endmodule

/* File: tb/tlc_mac_model.sv */
// Behavioural MAC: holds transmit enable for a commanded number of cycles
module tlc_mac_model (
	input  wire logic        clock,
	input  wire logic        go,
	input  wire logic [15:0] len,
	output logic             tx_en
);
	int n = 0;
	initial tx_en = 1'b0;
	always @(posedge clock) begin
		if (go) begin
			tx_en <= 1'b1;
			n <= int'(len);
		end else if (n > 1)
			n <= n - 1;
		else
			tx_en <= 1'b0;
	end
endmodule

/* File: tb/tlc_link_ctrl_assertions.sv */
// Port-level assertions of the 10 Mb/s link control block
module tlc_link_ctrl_assertions
	import tlc_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [4:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        mac_tx_en,
	input wire logic        mac_crs,
	input wire logic        mac_col,
	input wire logic        rx_activity,
	input wire logic        pll_acquire,
	input wire logic        line_tx_en,
	input wire logic        line_idle_marker
);
	logic fd_q;
	logic rp_q;
	logic sqi_q;
	// Shadow of the duplex and repeater mode bits and the heartbeat inhibit bit, since the registers are not visible here
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fd_q  <= 1'b0;
			rp_q  <= 1'b0;
			sqi_q <= 1'b0;
		end else if (reg_wr && reg_addr == REG_MODE) begin
			fd_q <= reg_wdata[MD_FULL_BIT];
			rp_q <= reg_wdata[MD_RPT_BIT];
		end else if (reg_wr && reg_addr == REG_OPS) begin
			sqi_q <= reg_wdata[OP_SQE_INH_BIT];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// A write in the same cycle can flip the mode, so such cycles are left out
	property p_pll;
		rst_n |=> pll_acquire == $past(rx_activity);
	endproperty
	property p_crs_half;
		!fd_q && !rp_q && !reg_wr && ($rose(mac_tx_en) || rx_activity) |=> mac_crs;
	endproperty
	property p_crs_rx;
		(fd_q || rp_q) && !reg_wr |=> mac_crs == $past(rx_activity);
	endproperty
	property p_col_ovl;
		!fd_q && !reg_wr && mac_tx_en && rx_activity |=> mac_col;
	endproperty
	property p_fd_col;
		fd_q && !reg_wr |=> !mac_col;
	endproperty
	property p_tx_gate;
		line_tx_en |-> $past(mac_tx_en);
	endproperty
	property p_marker;
		$fell(mac_tx_en) && line_tx_en |=> line_idle_marker ##1 !line_idle_marker;
	endproperty
	property p_sqe_off;
		$fell(mac_tx_en) && line_tx_en && sqi_q && !rx_activity |=> !mac_col;
	endproperty
	property p_sqe_len;
		$fell(mac_tx_en) && line_tx_en && !rx_activity ##1 mac_col |-> ##199 mac_col ##1 !mac_col;
	endproperty
	a_pll: assert property (p_pll) else $error("acquire not following activity");
	a_crs_half: assert property (p_crs_half) else $error("carrier missing");
	a_crs_rx: assert property (p_crs_rx) else $error("carrier not receive only");
	a_col_ovl: assert property (p_col_ovl) else $error("overlap without collision");
	a_fd_col: assert property (p_fd_col) else $error("collision in full duplex");
	a_tx_gate: assert property (p_tx_gate) else $error("line transmit without request");
	a_marker: assert property (p_marker) else $error("idle marker wrong");
	a_sqe_off: assert property (p_sqe_off) else $error("heartbeat while inhibited");
	a_sqe_len: assert property (p_sqe_len) else $error("heartbeat length wrong");
	c_sqe: cover property ($fell(mac_tx_en) ##1 mac_col);
	c_ovl: cover property (mac_tx_en && rx_activity);
	c_jab: cover property (mac_tx_en && !line_tx_en && mac_col);
endmodule
bind tlc_link_ctrl tlc_link_ctrl_assertions u_tlc_link_ctrl_assertions (.clock(clock),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.mac_tx_en(mac_tx_en), .mac_crs(mac_crs), .mac_col(mac_col), .rx_activity(rx_activity),
	.pll_acquire(pll_acquire), .line_tx_en(line_tx_en), .line_idle_marker(line_idle_marker));

/* File: tb/test_ten_mbit_link_control.sv */
// Self-checking bench of the 10 Mb/s link control block
module test_ten_mbit_link_control
	import tlc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LP = 200;
	localparam int TMO = 2000;
	localparam int JM = 500;
	localparam int JO = 300;
	localparam int SQ = 200;
	localparam logic [15:0] ST_M = 16'h0001 << ST_LINK_BIT;
	localparam logic [15:0] DT_M = 16'h0001 << DT_LINK_BIT;
	localparam logic [15:0] JB_M = 16'h0001 << DT_JAB_BIT;
	logic        clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go = 0, ce = 1;
	logic        rx_activity = 0, rx_pll_lock = 0, rx_link_pulse = 0, rx_idle_marker = 0;
	logic [4:0]  reg_addr = '0;
	logic [15:0] reg_wdata = '0, len = '0, v, reg_rdata;
	logic        mac_tx_en, mac_clk, mac_crs, mac_col, pll_acquire, line_tx_en;
	logic        line_link_pulse, line_idle_marker;
	int          bad_count = 0, n_compared = 0, n;
	always #2.5 clock = ~clock;
	tlc_mac_model u_tlc_mac_model (.clock(clock), .go(go), .len(len), .tx_en(mac_tx_en));
	// Shortened timing parameters keep the run to a few thousand cycles
	tlc_link_ctrl #(.LP_PERIOD(LP), .LINK_TMO(TMO), .JAB_MAX(JM), .JAB_OFF(JO), .SQE_LEN(SQ),
		.VALID_LEN(60)) u_tlc_link_ctrl (.clock(clock), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mac_tx_en(mac_tx_en), .mac_clk(mac_clk), .mac_crs(mac_crs),
		.mac_col(mac_col), .rx_activity(rx_activity), .rx_pll_lock(rx_pll_lock),
		.rx_link_pulse(rx_link_pulse), .rx_idle_marker(rx_idle_marker),
		.pll_acquire(pll_acquire), .line_tx_en(line_tx_en),
		.line_link_pulse(line_link_pulse), .line_idle_marker(line_idle_marker));
	task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", s, exp, seen);
		end
	endtask
	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task tx(input int l);
		@(posedge clock);
		len <= 16'(l);
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
	endtask
	task wmark;
		for (int i = 0; i < 300 && line_idle_marker !== 1'b1; i++)
			cyc(1);
	endtask
	// Cycles between two rising edges of the interface clock or the link pulse
	task per(input bit sel);
		int k;
		logic s, p;
		k = -100000;
		n = 0;
		p = 1'b1;
		repeat (600) begin
			cyc(1);
			s = sel ? line_link_pulse : mac_clk;
			if (s && !p && k > 0 && n == 0)
				n = k;
			if (s && !p)
				k = 0;
			k++;
			p = s;
		end
	endtask
	task pulses(input int c);
		repeat (c) begin
			@(posedge clock);
			rx_link_pulse <= 1'b1;
			@(posedge clock);
			rx_link_pulse <= 1'b0;
			cyc(8);
		end
	endtask
	task t_regs;
		rd(REG_OPS);
		chk("ops reset", v, 16'h0000);
		wr(REG_OPS, 16'hffff);
		rd(REG_OPS);
		chk("ops rw", v, 16'h0025);
		wr(REG_OPS, 16'h0000);
		wr(5'h1f, 16'hffff);
		rd(5'h1f);
		chk("unmapped", v, 16'h0000);
	endtask
	task t_clocks;
		per(0);
		chk("nibble clk", 16'(n), 16'(4 * MII_HALF_CYC / 2));
		wr(REG_MODE, 16'h0001 << MD_SERIAL_BIT);
		per(0);
		chk("serial clk", 16'(n), 16'(2 * SER_HALF_CYC));
		wr(REG_MODE, 16'h0000);
		per(1);
		chk("pulse period", 16'(n), 16'(LP));
		// One nibble half period frozen: a running divider would have toggled
		v = 16'(mac_clk);
		@(posedge clock);
		ce <= 1'b0;
		cyc(MII_HALF_CYC);
		chk("ce freeze", 16'(mac_clk), v);
		@(posedge clock);
		ce <= 1'b1;
	endtask
	task t_link;
		pulses(7);
		rd(REG_STATUS);
		rd(REG_STATUS);
		chk("seven pulses", v & ST_M, 16'h0000);
		pulses(1);
		rd(REG_STATUS);
		chk("up no set", v & ST_M, 16'h0000);
		rd(REG_STATUS);
		chk("up reread", v & ST_M, ST_M);
		rd(REG_DETAIL);
		chk("detail link", v & DT_M, DT_M);
	endtask
	task t_sqe;
		tx(30);
		wmark;
		chk("marker", 16'(line_idle_marker), 16'h0001);
		chk("sqe on", 16'(mac_col), 16'h0001);
		cyc(SQ - 1);
		chk("sqe last", 16'(mac_col), 16'h0001);
		cyc(1);
		chk("sqe off", 16'(mac_col), 16'h0000);
		wr(REG_OPS, 16'h0001 << OP_SQE_INH_BIT);
		tx(30);
		wmark;
		chk("sqe inhibited", 16'(mac_col), 16'h0000);
		wr(REG_OPS, 16'h0000);
		cyc(TMO + 100);
		rd(REG_STATUS);
		rd(REG_STATUS);
		chk("link drop", v & ST_M, 16'h0000);
		tx(30);
		wmark;
		chk("sqe link down", 16'(mac_col), 16'h0000);
	endtask
	task t_jab;
		wr(REG_OPS, 16'h0001 << OP_JAB_INH_BIT);
		tx(JM + 100);
		cyc(JM + 20);
		chk("jab inhibited", 16'(line_tx_en), 16'h0001);
		cyc(200);
		wr(REG_OPS, 16'h0000);
		tx(JM + 100);
		cyc(JM + 20);
		chk("jab col", 16'(mac_col), 16'h0001);
		chk("jab gate", 16'(line_tx_en), 16'h0000);
		cyc(JO + 100);
		rd(REG_DETAIL);
		chk("jab flag", v & JB_M, JB_M);
		rd(REG_DETAIL);
		chk("jab reread", v & JB_M, 16'h0000);
	endtask
	task t_data(input logic m);
		@(posedge clock);
		rx_activity <= 1'b1;
		rx_pll_lock <= 1'b1;
		n = 0;
		repeat (LP + 50) begin
			cyc(1);
			n += int'(mac_col);
		end
		chk("rx col", 16'(n), 16'h0000);
		@(posedge clock);
		rx_idle_marker <= m;
		@(posedge clock);
		rx_idle_marker <= 1'b0;
		rx_activity <= 1'b0;
		rx_pll_lock <= 1'b0;
		rd(REG_STATUS);
		rd(REG_STATUS);
		chk("data link", v & ST_M, m ? ST_M : 16'h0000);
	endtask
	task t_duplex;
		logic [15:0] md[3];
		md = '{16'h0000, 16'h0001 << MD_FULL_BIT, 16'h0001 << MD_RPT_BIT};
		for (int i = 0; i < 3; i++) begin
			wr(REG_MODE, md[i]);
			tx(100);
			cyc(5);
			chk("tx crs", 16'(mac_crs), 16'(i == 0));
			@(posedge clock);
			rx_activity <= 1'b1;
			cyc(5);
			chk("ovl col", 16'(mac_col), 16'(i != 1));
			chk("rx crs", 16'(mac_crs), 16'h0001);
			@(posedge clock);
			rx_activity <= 1'b0;
			cyc(400);
		end
	endtask
	initial begin
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		t_regs;
		t_clocks;
		t_link;
		t_sqe;
		t_jab;
		t_data(1'b0);
		t_data(1'b1);
		t_duplex;
		print_verdict;
	end
	initial begin
		repeat (30000) @(posedge clock);
		bad_count++;
		print_verdict;
	end
endmodule
